//--- fault_trip_latch_test.sv
// self-checking bench for the fault trip latch
// assumes the field model drives the pins and apb reaches the registers
`timescale 1ns/1ps
module fault_trip_latch_test;
    logic        core_clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, err, op_req = 0, ind_req = 0, op_rst, ind_rst;
    logic [37:0] src_req = '0, fault_src;
    logic [4:0]  outs;
    int          fails = 0, checks = 0;
    // ========================================================
    // clock, design and field model
    always #4 core_clk_i = ~core_clk_i;
    fts_field field (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .src_req_i(src_req),
        .op_req_i(op_req), .ind_req_i(ind_req), .fault_src_o(fault_src),
        .op_reset_o(op_rst), .ind_reset_o(ind_rst));
    fts_top uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .fault_src_i(fault_src), .operational_reset_in_i(op_rst),
        .indication_reset_in_i(ind_rst), .fault_relay_o(outs[0]),
        .soft_stop1_open_o(outs[1]), .soft_stop2_open_o(outs[2]),
        .safety_stop_open_o(outs[3]), .fault_ind_o(outs[4]));
    // ========================================================
    // shared tasks
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge core_clk_i); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20) begin fails++; complete_run(); end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge core_clk_i);
    endtask : apb
    // pin to output takes about six edges; eight leaves margin
    task automatic settle();
        repeat (8) @(posedge core_clk_i);
    endtask : settle
    task automatic pulse(input int idx);
        src_req[idx] <= 1'b1; settle();
        src_req[idx] <= 1'b0; settle();
    endtask : pulse
    // parameter rise on both reset bits; written low first so each call rises
    task automatic clear_all();
        apb(1, fts_pkg::CTRL_OFS, 32'h0); apb(1, fts_pkg::CTRL_OFS, 32'h3); settle();
    endtask : clear_all
    // ========================================================
    // scenarios
    task automatic t_reset();
        chk(outs, 5'h00);
        apb(0, fts_pkg::CTRL_OFS, 0);   chk(rd, 32'h0);
        apb(0, fts_pkg::SEL_LO_OFS, 0); chk(rd, 32'h55555555);
        apb(0, fts_pkg::SEL_HI_OFS, 0); chk(rd, 32'h5);
        apb(0, 8'h40, 0); chk(rd, 32'h0); chk(err, 32'h1);
        apb(0, 8'h02, 0); chk(err, 1'b1);
    endtask : t_reset
    // codes 65..75 each latch their own bit and open both soft stops
    task automatic t_singles();
        for (int c = 65; c <= 75; c++) begin
            pulse(c - 38);
            chk(outs, 5'h17);
            apb(0, 8'h18, 0); chk(rd, 32'h1 << (c - 65));
            clear_all();
            chk(outs, 5'h00);
        end
    endtask : t_singles
    task automatic t_set_wins();
        src_req[27] <= 1'b1; settle();
        op_req <= 1'b1; settle();
        chk(outs, 5'h17);
        apb(0, 8'h38, 0); chk(rd, 32'h1);
        src_req[27] <= 1'b0; settle();
        chk(outs, 5'h10);
        apb(0, 8'h38, 0); chk(rd, 32'h0);
        op_req <= 1'b0; ind_req <= 1'b1; settle();
        chk(outs, 5'h00);
        ind_req <= 1'b0;
        pulse(27);
        apb(1, fts_pkg::CTRL_OFS, 32'h0); apb(1, fts_pkg::CTRL_OFS, 32'h1); settle();
        chk(outs, 5'h10);
        apb(1, fts_pkg::CTRL_OFS, 32'h3); settle();
        chk(outs, 5'h00);
    endtask : t_set_wins
    task automatic t_early();
        logic [2:0] eff [1:3] = '{3'h3, 3'h1, 3'h2};
        for (int s = 1; s <= 3; s++) begin
            // group 16 (first code 58) sits in the low bits of the upper selection word
            apb(1, fts_pkg::SEL_HI_OFS, 32'h4 | s);
            pulse(16);
            chk(outs, {2'b10, eff[s][1:0], 1'b1});
            apb(0, 8'h10, 0); chk(rd, 32'h0);
            apb(0, 8'h14, 0); chk(rd, 32'h1 << (24 + s));
            apb(0, 8'h24, 0); chk(rd, 32'h1 << (24 + s));
            clear_all();
        end
        // selection 0 switches the group off: nothing may latch or open
        apb(1, fts_pkg::SEL_HI_OFS, 32'h4);
        pulse(16);
        chk(outs, 5'h00);
        apb(0, 8'h14, 0); chk(rd, 32'h0);
        apb(1, fts_pkg::SEL_HI_OFS, 32'h5);
    endtask : t_early
    task automatic t_earth();
        logic [2:0] eff [1:3] = '{3'h0, 3'h3, 3'h4};
        for (int s = 1; s <= 3; s++) begin
            apb(1, fts_pkg::SEL_HI_OFS, {28'h0, s[1:0], 2'b01});
            pulse(17);
            chk(outs, {1'b1, eff[s], 1'b1});
            apb(0, 8'h14, 0); chk(rd, 32'h1 << (27 + s));
            clear_all();
        end
        apb(1, fts_pkg::SEL_HI_OFS, 32'h5);
    endtask : t_earth
    task automatic t_cfg7();
        apb(1, fts_pkg::CTRL_OFS, 32'h1C);
        pulse(18); settle();
        chk(outs, 5'h08);
        apb(0, 8'h20, 0); chk(rd, 32'h0);
        apb(1, fts_pkg::CTRL_OFS, 32'h0); settle();
        chk(outs, 5'h00);
    endtask : t_cfg7
    // ========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        t_reset();
        t_singles();
        t_set_wins();
        t_early();
        t_earth();
        t_cfg7();
        complete_run();
    end
endmodule : fault_trip_latch_test

//--- fts_field.sv
// field side model: fault supervision sources and operator reset pins
// assumes the bench requests levels; pins change only after clock edges
`timescale 1ns/1ps
module fts_field (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [37:0] src_req_i,
    input  wire logic        op_req_i,
    input  wire logic        ind_req_i,
    output logic      [37:0] fault_src_o,
    output logic             op_reset_o,
    output logic             ind_reset_o
);
    // ========================================================
    // pin drivers
    // supervision pins are levels held by the field, quiet during reset
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_src_o <= '0;
            op_reset_o  <= 1'b0;
            ind_reset_o <= 1'b0;
        end else begin
            fault_src_o <= src_req_i;
            op_reset_o  <= op_req_i;
            ind_reset_o <= ind_req_i;
        end
    end
endmodule : fts_field

//--- fts_pkg.sv
// constants, register map and fault tables of the fault trip latch
// assumes a 32-bit apb slave with byte addresses on 8 bits
package fts_pkg;
    // ========================================================
    // sizes
    localparam int NUM_CODES  = 75;
    localparam int NUM_GROUPS = 18;
    localparam int NUM_SINGLE = 20;
    localparam int NUM_SRC    = NUM_GROUPS + NUM_SINGLE;
    localparam int EARTH_GRP  = 17;
    localparam logic [2:0] SAFETY_OFF_CFG = 3'h7;

    // ========================================================
    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] SEL_LO_OFS = 8'h04;
    localparam logic [7:0] SEL_HI_OFS = 8'h08;
    localparam logic [7:0] OUT_OFS    = 8'h0C;
    localparam logic [3:0] OP_BANK    = 4'h1;
    localparam logic [3:0] IND_BANK   = 4'h2;
    localparam logic [3:0] LIVE_BANK  = 4'h3;

    // ========================================================
    // field positions and reset values
    localparam int CTRL_OP_RST_BIT  = 0;
    localparam int CTRL_IND_RST_BIT = 1;
    localparam int CTRL_CFG_LSB     = 2;
    localparam logic [4:0]  CTRL_RST   = 5'h00;
    localparam logic [31:0] SEL_LO_RST = 32'h55555555;
    localparam logic [3:0]  SEL_HI_RST = 4'h5;

    // ========================================================
    // first fault code of each source: selectable groups, then singles
    localparam logic [6:0] SRC_CODE [NUM_SRC] = '{
        7'h04, 7'h07, 7'h0A, 7'h0E, 7'h15, 7'h18, 7'h1B, 7'h1E, 7'h22,
        7'h25, 7'h28, 7'h2B, 7'h2E, 7'h31, 7'h34, 7'h37, 7'h3A, 7'h3D,
        7'h01, 7'h02, 7'h03, 7'h0D, 7'h11, 7'h12, 7'h13, 7'h14, 7'h21,
        7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h48, 7'h49,
        7'h4A, 7'h4B};

    // effect bits {safety stop, soft stop 2, soft stop 1}
    localparam logic [2:0] EFF_NONE = 3'h0;
    localparam logic [2:0] EFF_S1   = 3'h1;
    localparam logic [2:0] EFF_S2   = 3'h2;
    localparam logic [2:0] EFF_BOTH = 3'h3;
    localparam logic [2:0] EFF_SO   = 3'h4;
endpackage : fts_pkg

//--- fts_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
// assumes one clock; outputs move once stages two and three agree
`timescale 1ns/1ps
module fts_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // ========================================================
    // first stage feeds only the second
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            meta   <= async_i;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    // ========================================================
    // take a bit only when two and three agree, else hold
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_o <= '0;
        end else begin
            sync_o <= (stage2 & stage3) | (sync_o & (stage2 | stage3));
        end
    end
endmodule : fts_sync

//--- fts_top.sv
// fault trip latch: per-code operational and indication latches,
// relay and safety-stop outputs, apb register access
// assumes fault sources and reset inputs are asynchronous pins
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module fts_top (
    input  wire logic                         core_clk_i,
    input  wire logic                         rst_n_i,
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [7:0]                   paddr_i,
    input  wire logic [31:0]                  pwdata_i,
    output logic      [31:0]                  prdata_o,
    output logic                              pready_o,
    output logic                              pslverr_o,
    input  wire logic [fts_pkg::NUM_SRC-1:0]  fault_src_i,
    input  wire logic                         operational_reset_in_i,
    input  wire logic                         indication_reset_in_i,
    output logic                              fault_relay_o,
    output logic                              soft_stop1_open_o,
    output logic                              soft_stop2_open_o,
    output logic                              safety_stop_open_o,
    output logic                              fault_ind_o
);
    localparam int NC = fts_pkg::NUM_CODES;

    logic [fts_pkg::NUM_SRC+1:0] pins_sync;
    logic [fts_pkg::NUM_SRC-1:0] src;
    logic                        op_rst_pin;
    logic                        ind_rst_pin;
    logic [4:0]                  ctrl;
    logic [31:0]                 sel_lo;
    logic [3:0]                  sel_hi;
    logic                        op_param_d;
    logic                        ind_param_d;
    logic                        op_edge;
    logic                        ind_edge;
    logic                        op_clr;
    logic                        ind_clr;
    logic                        safety_off;
    logic [NC-1:0]               cond;
    logic [NC-1:0]               op_latch;
    logic [NC-1:0]               ind_latch;
    logic [NC-1:0]               live;
    logic [NC-1:0]               mask_s1;
    logic [NC-1:0]               mask_s2;
    logic [NC-1:0]               mask_so;
    logic                        wr_en;
    logic                        rd_en;
    logic [31:0]                 next_rdata;
    logic                        next_err;

    // ========================================================
    // helpers
    function automatic logic [1:0] group_sel(input logic [35:0] all, input int g);
        group_sel = all[2*g +: 2];
    endfunction : group_sel

    function automatic logic [31:0] bank_word(input logic [NC-1:0] v,
                                              input logic [1:0] idx);
        logic [95:0] pad;
        pad = {{(96-NC){1'b0}}, v};
        bank_word = pad[32*idx +: 32];
    endfunction : bank_word

    function automatic logic [2:0] early_effect(input logic [1:0] s);
        case (s)
            2'h1:    early_effect = fts_pkg::EFF_BOTH;
            2'h2:    early_effect = fts_pkg::EFF_S1;
            2'h3:    early_effect = fts_pkg::EFF_S2;
            default: early_effect = fts_pkg::EFF_NONE;
        endcase
    endfunction : early_effect

    // ========================================================
    // pin synchroniser for fault sources and reset inputs
    fts_sync #(
        .WIDTH (fts_pkg::NUM_SRC + 2)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .async_i    ({indication_reset_in_i, operational_reset_in_i, fault_src_i}),
        .sync_o     (pins_sync)
    );

    assign src         = pins_sync[fts_pkg::NUM_SRC-1:0];
    assign op_rst_pin  = pins_sync[fts_pkg::NUM_SRC];
    assign ind_rst_pin = pins_sync[fts_pkg::NUM_SRC+1];
    assign safety_off  = (ctrl[fts_pkg::CTRL_CFG_LSB +: 3] == fts_pkg::SAFETY_OFF_CFG);

    // ========================================================
    // fault conditions per code, bit k is code k+1
    always_comb begin
        logic [1:0] s;
        logic [6:0] c;
        s    = 2'h0;
        c    = 7'h0;
        cond = '0;
        for (int g = 0; g < fts_pkg::NUM_GROUPS; g++) begin
            s = group_sel({sel_hi, sel_lo}, g);
            c = fts_pkg::SRC_CODE[g];
            if (s != 2'h0) begin
                cond[c + s - 2] = src[g];
            end
        end
        for (int i = fts_pkg::NUM_GROUPS; i < fts_pkg::NUM_SRC; i++) begin
            c = fts_pkg::SRC_CODE[i];
            cond[c - 1] = src[i];
        end
        if (safety_off) begin
            cond = '0;
        end
    end

    // ========================================================
    // output effect of each code, constant after folding
    always_comb begin
        logic [2:0] e;
        logic [6:0] c;
        e       = fts_pkg::EFF_NONE;
        c       = 7'h0;
        mask_s1 = '0;
        mask_s2 = '0;
        mask_so = '0;
        for (int g = 0; g < fts_pkg::NUM_GROUPS; g++) begin
            for (int s = 1; s < 4; s++) begin
                c = fts_pkg::SRC_CODE[g] + 7'(s - 1);
                if (g == fts_pkg::EARTH_GRP) begin
                    e = (s == 2) ? fts_pkg::EFF_BOTH :
                        (s == 3) ? fts_pkg::EFF_SO : fts_pkg::EFF_NONE;
                end else begin
                    e = early_effect(2'(s));
                end
                mask_s1[c-1] = e[0];
                mask_s2[c-1] = e[1];
                mask_so[c-1] = e[2];
            end
        end
        for (int i = fts_pkg::NUM_GROUPS; i < fts_pkg::NUM_SRC; i++) begin
            c = fts_pkg::SRC_CODE[i];
            // direct trips open safety stop, encoder class opens both
            if (c < 7'h41) begin
                mask_so[c-1] = 1'b1;
            end else begin
                mask_s1[c-1] = 1'b1;
                mask_s2[c-1] = 1'b1;
            end
        end
    end

    // ========================================================
    // reset parameter rise detection, one-cycle pulses
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_param_d  <= 1'b0;
            ind_param_d <= 1'b0;
        end else begin
            op_param_d  <= ctrl[fts_pkg::CTRL_OP_RST_BIT];
            ind_param_d <= ctrl[fts_pkg::CTRL_IND_RST_BIT];
        end
    end

    assign op_edge  = ctrl[fts_pkg::CTRL_OP_RST_BIT] & ~op_param_d;
    assign ind_edge = ctrl[fts_pkg::CTRL_IND_RST_BIT] & ~ind_param_d;
    assign op_clr   = op_rst_pin | op_edge;
    assign ind_clr  = ind_rst_pin | ind_edge;

    // ========================================================
    // set-dominant latches; a held reset cannot mask an active fault
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_latch  <= '0;
            ind_latch <= '0;
        end else begin
            op_latch  <= cond | (op_latch & {NC{~op_clr}});
            ind_latch <= cond | (ind_latch & {NC{~ind_clr}});
        end
    end

    // ========================================================
    // live present flags, not latched
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            live <= '0;
        end else begin
            live <= cond;
        end
    end

    // ========================================================
    // outputs; only operational latches reach relays
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_relay_o      <= 1'b0;
            soft_stop1_open_o  <= 1'b0;
            soft_stop2_open_o  <= 1'b0;
            safety_stop_open_o <= 1'b0;
            fault_ind_o        <= 1'b0;
        end else begin
            fault_relay_o      <= |op_latch;
            soft_stop1_open_o  <= |(op_latch & mask_s1);
            soft_stop2_open_o  <= |(op_latch & mask_s2);
            safety_stop_open_o <= |(op_latch & mask_so) | safety_off;
            fault_ind_o        <= |ind_latch;
        end
    end

    // ========================================================
    // apb: one wait state, write takes effect with pready
    assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
    assign rd_en = psel_i & penable_i & ~pready_o & ~pwrite_i;

    always_comb begin
        next_rdata = 32'h0;
        next_err   = 1'b0;
        case (paddr_i[7:4])
            4'h0: begin
                case (paddr_i[3:0])
                    fts_pkg::CTRL_OFS[3:0]:   next_rdata = {27'h0, ctrl};
                    fts_pkg::SEL_LO_OFS[3:0]: next_rdata = sel_lo;
                    fts_pkg::SEL_HI_OFS[3:0]: next_rdata = {28'h0, sel_hi};
                    fts_pkg::OUT_OFS[3:0]:    next_rdata = {27'h0, fault_ind_o,
                        safety_stop_open_o, soft_stop2_open_o, soft_stop1_open_o,
                        fault_relay_o};
                    default:                  next_err   = 1'b1;
                endcase
            end
            fts_pkg::OP_BANK:   next_rdata = bank_word(op_latch, paddr_i[3:2]);
            fts_pkg::IND_BANK:  next_rdata = bank_word(ind_latch, paddr_i[3:2]);
            fts_pkg::LIVE_BANK: next_rdata = bank_word(live, paddr_i[3:2]);
            default:            next_err   = 1'b1;
        endcase
        if (paddr_i[1:0] != 2'h0 || paddr_i[3:2] == 2'h3 && paddr_i[7:4] != 4'h0) begin
            next_err = 1'b1;
        end
    end

    // ready and response
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & next_err;
            if (rd_en) begin
                prdata_o <= next_err ? 32'h0 : next_rdata;
            end
        end
    end

    // writable registers; status banks are read only
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl   <= fts_pkg::CTRL_RST;
            sel_lo <= fts_pkg::SEL_LO_RST;
            sel_hi <= fts_pkg::SEL_HI_RST;
        end else if (wr_en) begin
            case (paddr_i)
                fts_pkg::CTRL_OFS:   ctrl   <= pwdata_i[4:0];
                fts_pkg::SEL_LO_OFS: sel_lo <= pwdata_i;
                fts_pkg::SEL_HI_OFS: sel_hi <= pwdata_i[3:0];
                default: ;
            endcase
        end
    end

    // ========================================================
    // assertions
    a_op_set_dom: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        cond != '0 |=> (op_latch & $past(cond)) == $past(cond))
        else $error("operational latch lost an active fault");

    a_ind_set_same: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ##1 (ind_latch & $past(cond)) == $past(cond))
        else $error("indication latch not set with its fault");

    a_relay_any_op: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        op_latch != '0 |=> fault_relay_o)
        else $error("fault relay missing while a latch is set");

    a_ind_no_relay: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        op_latch == '0 && !safety_off |=> !soft_stop1_open_o && !soft_stop2_open_o
        && !safety_stop_open_o && !fault_relay_o)
        else $error("output moved without operational latch");

    a_op_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        op_clr && cond == '0 |=> op_latch == '0)
        else $error("operational latches not cleared");

    a_ind_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ind_clr && cond == '0 |=> ind_latch == '0)
        else $error("indication latches not cleared");

    a_ind_keep: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        op_clr && !ind_clr |=> (ind_latch & $past(ind_latch)) == $past(ind_latch))
        else $error("indication lost on operational reset");

    a_live_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ##1 live == $past(cond))
        else $error("live flags differ from conditions");

    a_early_sel2: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        src[16] && sel_hi[1:0] == 2'h2 && !safety_off |=> op_latch[58] ##1
        soft_stop1_open_o)
        else $error("early stage selection two failed");

    a_earth_so: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        src[17] && sel_hi[3:2] == 2'h3 && !safety_off |=> op_latch[62] ##1
        safety_stop_open_o)
        else $error("earth fault selection three failed");

    a_encoder_trip: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        src[27] && !safety_off |-> ##2 soft_stop1_open_o && soft_stop2_open_o)
        else $error("encoder fault did not open soft stops");

    a_board_trip: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        src[33] && !safety_off |=> op_latch[70])
        else $error("board fault not latched");

    a_pos_trip: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        src[35] && !safety_off |=> op_latch[72] ##1 soft_stop2_open_o)
        else $error("position error not tripped");

    a_start_trip: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        src[37] && !safety_off |=> op_latch[74] && ind_latch[74])
        else $error("start sequence fault not latched");

    a_safety_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        safety_off |-> cond == '0 ##1 safety_stop_open_o)
        else $error("configuration seven not honoured");

    a_edge_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        op_edge |=> !op_edge)
        else $error("parameter edge wider than one cycle");

    c_op_trip: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        fault_relay_o ##1 op_clr ##1 !fault_relay_o);
    c_ind_hold: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        op_clr && !ind_clr && ind_latch != '0);
    c_earth_none: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        op_latch[60] && !soft_stop1_open_o);
endmodule : fts_top
